// [fpcp_pkg.sv]
// Shared constants, types and lookups for the parallel configuration port
package fpcp_pkg;
   // ----------------------------------------
   // Load widths
   // ----------------------------------------
   typedef enum logic [1:0] {FPCP_W8, FPCP_W16, FPCP_W32} fpcp_width_t;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 125;
   localparam int T_CFG_US = 2;
   localparam int CFG_CYC = T_CFG_US * CLK_MHZ;
   localparam int T_STATUS_MIN_US = 268;
   localparam int STATUS_CYC = T_STATUS_MIN_US * CLK_MHZ;
   localparam int T_CF2CK_US = 1506;
   localparam int CF2CK_CYC = T_CF2CK_US * CLK_MHZ;
   localparam int T_ST2CK_US = 2;
   localparam int ST2CK_CYC = T_ST2CK_US * CLK_MHZ;
   localparam int T_POR_FAST_MS = 4;
   localparam int POR_FAST_CYC = T_POR_FAST_MS * 1000 * CLK_MHZ;
   localparam int T_POR_STD_MS = 100;
   localparam int POR_STD_CYC = T_POR_STD_MS * 1000 * CLK_MHZ;
   localparam int T_CD2UM_MIN_US = 175;
   localparam int CD2UM_CYC = T_CD2UM_MIN_US * CLK_MHZ;
   localparam int T_LCLK_MIN_NS = 8;
   localparam int CD2CU_PERIODS = 4;
   localparam int CD2CU_CYC = (CD2CU_PERIODS * T_LCLK_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int UM_USER_CLKS = 8576;
   localparam int HOST_HALF_CYC = 4;
   localparam int INIT_FALLS = 2;

   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [2:0] DEV_SYNC_RST = 3'h2;
   localparam logic [2:0] HOST_SYNC_RST = 3'h0;

   // ----------------------------------------
   // Lookups
   // ----------------------------------------
   function automatic logic [3:0] fpcp_ratio(fpcp_width_t w, logic decomp, logic secure);
      logic [3:0] r;
      r = 4'h1;
      unique case (w)
         FPCP_W8: r = decomp ? 4'h2 : 4'h1;
         FPCP_W16: r = decomp ? 4'h4 : (secure ? 4'h2 : 4'h1);
         FPCP_W32: r = decomp ? 4'h8 : (secure ? 4'h4 : 4'h1);
         default: r = 4'h1;
      endcase
      return r;
   endfunction

   function automatic logic [31:0] fpcp_lane_mask(fpcp_width_t w);
      logic [31:0] m;
      m = 32'hffffffff;
      unique case (w)
         FPCP_W8: m = 32'h000000ff;
         FPCP_W16: m = 32'h0000ffff;
         FPCP_W32: m = 32'hffffffff;
         default: m = 32'h000000ff;
      endcase
      return m;
   endfunction
endpackage

// [fpcp_if.sv]
// Pins between configuration host and configured device
`timescale 1ns/1ns
interface fpcp_if;
   logic load_clock;
   logic reconfig_request_n;
   logic [31:0] data;
   logic dev_status_o;
   logic dev_status_oe;
   logic dev_done_o;
   logic dev_done_oe;
   logic dev_idone_o;
   logic dev_idone_oe;
   wire config_status_n;
   wire load_complete;
   wire init_done;

   // Open-drain lines with pull-ups
   assign config_status_n = dev_status_oe ? dev_status_o : 1'b1;
   assign load_complete = dev_done_oe ? dev_done_o : 1'b1;
   assign init_done = dev_idone_oe ? dev_idone_o : 1'b1;

   modport dev (
      input load_clock, reconfig_request_n, data, config_status_n, load_complete, init_done,
      output dev_status_o, dev_status_oe, dev_done_o, dev_done_oe, dev_idone_o, dev_idone_oe
   );
   modport host (
      output load_clock, reconfig_request_n, data,
      input config_status_n, load_complete, init_done
   );
endinterface

// [fpcp_dev.sv]
// Device end: receives configuration words and sequences to user mode
`timescale 1ns/1ns
// Functional notes
// - x8: ratio 1, two with decompression
// - x16 ratios 1/2/4, x32 ratios 1/4/8
// - Host clocks ratio times word rate
// - Host keeps ratio-1 edges after last word
// - User mode lines high; request low reconfigures
// - Status low during power-on delay
// - Load-complete low until all words received
// - Load-complete released after complete data set
// - Two falling edges start initialization
// - Load clock ignored after configuration
// - Init-done driven low until initialization ends
// - Width selects lanes; pins revert after
// - Host pauses clock low, data first
// - Request low pulls both lines low quickly
// - Host holds request low two microseconds
// - Status low pulse 268 to 1506 us
// - Host waits before first clock edge
// - Host respects maximum load clock rate
// - Internal oscillator wake 175 to 437 us
// - User clock wake: 4 periods + 8576
module fpcp_dev #(
   parameter int POR_FAST_CYC = fpcp_pkg::POR_FAST_CYC,
   parameter int POR_STD_CYC = fpcp_pkg::POR_STD_CYC,
   parameter int STATUS_CYC = fpcp_pkg::STATUS_CYC,
   parameter int CD2UM_CYC = fpcp_pkg::CD2UM_CYC,
   parameter int UM_USER_CLKS = fpcp_pkg::UM_USER_CLKS
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   fpcp_if.dev link,
   input wire fpcp_pkg::fpcp_width_t width_in,
   input wire logic decomp_in,
   input wire logic secure_in,
   input wire logic por_fast_in,
   input wire logic init_done_en_in,
   input wire logic user_clk_sel_in,
   input wire logic user_init_clock_in,
   input wire logic [31:0] words_expected_in,
   output logic [31:0] word_out,
   output logic word_valid_out,
   output logic user_mode_out
);
   // ----------------------------------------
   // Limits
   // ----------------------------------------
   localparam logic [23:0] POR_FAST_LIM = 24'(POR_FAST_CYC - 1);
   localparam logic [23:0] POR_STD_LIM = 24'(POR_STD_CYC - 1);
   localparam logic [23:0] STATUS_LIM = 24'(STATUS_CYC - 1);
   localparam logic [23:0] CD2UM_LIM = 24'(CD2UM_CYC - 1);
   localparam logic [23:0] CD2CU_LIM = 24'(fpcp_pkg::CD2CU_CYC - 1);
   localparam logic [13:0] UM_LIM = 14'(UM_USER_CLKS - 1);
   localparam logic [1:0] FALL_LIM = 2'(fpcp_pkg::INIT_FALLS - 1);

   typedef enum logic [2:0] {D_POR, D_HOLD, D_STAT, D_LOAD, D_INIT, D_WAKE, D_USER} fpcp_dstate_t;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [2:0] s1_r;
   logic [2:0] s2_r;
   logic [2:0] s3_r;
   logic [2:0] filt_r;
   logic [31:0] d1_r;
   logic [31:0] d2_r;
   logic [31:0] d3_r;
   wire [2:0] filt_nxt;
   wire lclk_rise;
   wire lclk_fall;
   wire uclk_rise;
   wire req_low;

   assign filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));
   assign lclk_rise = filt_nxt[0] & ~filt_r[0];
   assign lclk_fall = ~filt_nxt[0] & filt_r[0];
   assign uclk_rise = filt_nxt[2] & ~filt_r[2];
   assign req_low = ~filt_r[1];

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s1_r <= fpcp_pkg::DEV_SYNC_RST;
         s2_r <= fpcp_pkg::DEV_SYNC_RST;
         s3_r <= fpcp_pkg::DEV_SYNC_RST;
         filt_r <= fpcp_pkg::DEV_SYNC_RST;
         d1_r <= 32'h0;
         d2_r <= 32'h0;
         d3_r <= 32'h0;
      end else if (ce_in) begin
         s1_r <= {user_init_clock_in, link.reconfig_request_n, link.load_clock};
         s2_r <= s1_r;
         s3_r <= s2_r;
         filt_r <= filt_nxt;
         d1_r <= link.data;
         d2_r <= d1_r;
         d3_r <= d2_r;
      end
   end

   // ----------------------------------------
   // Mode straps
   // ----------------------------------------
   fpcp_pkg::fpcp_width_t width_r;
   logic decomp_r;
   logic secure_r;
   logic por_fast_r;
   logic idone_en_r;
   logic usel_r;
   logic [31:0] expect_r;
   fpcp_dstate_t st_r;
   fpcp_dstate_t st_nxt;
   wire strap_open;

   // Straps follow the pins while status is low, frozen once loading begins
   assign strap_open = (st_r == D_POR) || (st_r == D_HOLD) || (st_r == D_STAT);

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         width_r <= fpcp_pkg::FPCP_W8;
         decomp_r <= 1'b0;
         secure_r <= 1'b0;
         por_fast_r <= 1'b0;
         idone_en_r <= 1'b0;
         usel_r <= 1'b0;
         expect_r <= 32'h0;
      end else if (ce_in && strap_open) begin
         width_r <= width_in;
         decomp_r <= decomp_in;
         secure_r <= secure_in;
         por_fast_r <= por_fast_in;
         idone_en_r <= init_done_en_in;
         usel_r <= user_clk_sel_in;
         expect_r <= words_expected_in;
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   logic [23:0] tmr_r;
   logic [23:0] tmr_nxt;
   logic [3:0] edge_r;
   logic [3:0] edge_nxt;
   logic [31:0] words_r;
   logic [31:0] words_nxt;
   logic [1:0] fall_r;
   logic [1:0] fall_nxt;
   logic [13:0] ucnt_r;
   logic [13:0] ucnt_nxt;
   logic [31:0] word_nxt;
   logic valid_nxt;
   logic status_oe_r;
   logic done_oe_r;
   logic idone_oe_r;
   wire [23:0] por_lim;
   wire [3:0] ratio;
   wire [31:0] lane_word;

   assign por_lim = por_fast_r ? POR_FAST_LIM : POR_STD_LIM;
   assign ratio = fpcp_pkg::fpcp_ratio(width_r, decomp_r, secure_r);
   assign lane_word = d3_r & fpcp_pkg::fpcp_lane_mask(width_r);

   always_comb begin
      st_nxt = st_r;
      tmr_nxt = (&tmr_r) ? tmr_r : tmr_r + 24'h1;
      edge_nxt = edge_r;
      words_nxt = words_r;
      fall_nxt = fall_r;
      ucnt_nxt = ucnt_r;
      word_nxt = word_out;
      valid_nxt = 1'b0;
      unique case (st_r)
         D_POR: begin
            if (tmr_r >= por_lim) begin
               st_nxt = D_LOAD;
            end
         end
         D_HOLD: begin
            tmr_nxt = 24'h0;
            if (!req_low) begin
               st_nxt = D_STAT;
            end
         end
         D_STAT: begin
            if (tmr_r >= STATUS_LIM) begin
               st_nxt = D_LOAD;
            end
         end
         D_LOAD: begin
            edge_nxt = edge_r;
            if (lclk_rise) begin
               if (edge_r == 4'h0) begin
                  // First edge of a word latches it; the rest only count edge_r down
                  word_nxt = lane_word;
                  valid_nxt = 1'b1;
                  words_nxt = words_r + 32'h1;
                  edge_nxt = ratio - 4'h1;
                  if (words_nxt == expect_r) begin
                     st_nxt = D_INIT;
                     fall_nxt = 2'h0;
                  end
               end else begin
                  edge_nxt = edge_r - 4'h1;
               end
            end
         end
         D_INIT: begin
            tmr_nxt = 24'h0;
            ucnt_nxt = 14'h0;
            if (lclk_fall) begin
               fall_nxt = fall_r + 2'h1;
               if (fall_r == FALL_LIM) begin
                  st_nxt = D_WAKE;
               end
            end
         end
         D_WAKE: begin
            if (usel_r) begin
               if (tmr_r >= CD2CU_LIM && uclk_rise) begin
                  ucnt_nxt = ucnt_r + 14'h1;
                  if (ucnt_r == UM_LIM) begin
                     st_nxt = D_USER;
                  end
               end
            end else if (tmr_r >= CD2UM_LIM) begin
               st_nxt = D_USER;
            end
         end
         D_USER: begin
            tmr_nxt = 24'h0;
         end
         default: begin
            st_nxt = D_HOLD;
         end
      endcase
      if (req_low) begin
         st_nxt = D_HOLD;
         tmr_nxt = 24'h0;
         edge_nxt = 4'h0;
         words_nxt = 32'h0;
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st_r <= D_POR;
         tmr_r <= 24'h0;
         edge_r <= 4'h0;
         words_r <= 32'h0;
         fall_r <= 2'h0;
         ucnt_r <= 14'h0;
         word_out <= 32'h0;
         word_valid_out <= 1'b0;
         user_mode_out <= 1'b0;
         status_oe_r <= 1'b1;
         done_oe_r <= 1'b1;
         idone_oe_r <= 1'b0;
      end else if (ce_in) begin
         st_r <= st_nxt;
         tmr_r <= tmr_nxt;
         edge_r <= edge_nxt;
         words_r <= words_nxt;
         fall_r <= fall_nxt;
         ucnt_r <= ucnt_nxt;
         word_out <= word_nxt;
         word_valid_out <= valid_nxt;
         user_mode_out <= (st_nxt == D_USER);
         status_oe_r <= (st_nxt == D_POR) || (st_nxt == D_HOLD) || (st_nxt == D_STAT);
         done_oe_r <= (st_nxt != D_INIT) && (st_nxt != D_WAKE) && (st_nxt != D_USER);
         idone_oe_r <= idone_en_r && ((st_nxt == D_INIT) || (st_nxt == D_WAKE));
      end
   end

   // ----------------------------------------
   // Open-drain pins
   // ----------------------------------------
   assign link.dev_status_o = 1'b0;
   assign link.dev_status_oe = status_oe_r;
   assign link.dev_done_o = 1'b0;
   assign link.dev_done_oe = done_oe_r;
   assign link.dev_idone_o = 1'b0;
   assign link.dev_idone_oe = idone_oe_r;
endmodule

// [fpcp_host.sv]
// Host end: requests reconfiguration and pushes configuration words
`timescale 1ns/1ns
module fpcp_host #(
   parameter int CF2CK_CYC = fpcp_pkg::CF2CK_CYC
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic ce_in,
   fpcp_if.host link,
   input wire logic start_in,
   input wire fpcp_pkg::fpcp_width_t width_in,
   input wire logic decomp_in,
   input wire logic secure_in,
   input wire logic watch_status_in,
   input wire logic [31:0] words_total_in,
   input wire logic [31:0] word_in,
   input wire logic word_valid_in,
   output logic word_ready_out,
   output logic busy_out,
   output logic done_out
);
   localparam logic [17:0] CFG_LIM = 18'(fpcp_pkg::CFG_CYC - 1);
   localparam logic [17:0] ST2CK_LIM = 18'(fpcp_pkg::ST2CK_CYC - 1);
   localparam logic [17:0] CF2CK_LIM = 18'(CF2CK_CYC - 1);
   localparam logic [2:0] HALF_LIM = 3'(fpcp_pkg::HOST_HALF_CYC - 1);
   localparam logic [1:0] FALL_LIM = 2'(fpcp_pkg::INIT_FALLS - 1);

   typedef enum logic [2:0] {H_IDLE, H_REQ, H_WST, H_GAP, H_LOAD, H_WDONE, H_EDGES, H_END}
      fpcp_hstate_t;

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [2:0] s1_r;
   logic [2:0] s2_r;
   logic [2:0] s3_r;
   logic [2:0] filt_r;
   wire [2:0] filt_nxt;

   assign filt_nxt = (s2_r & s3_r) | (filt_r & (s2_r ^ s3_r));

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         s1_r <= fpcp_pkg::HOST_SYNC_RST;
         s2_r <= fpcp_pkg::HOST_SYNC_RST;
         s3_r <= fpcp_pkg::HOST_SYNC_RST;
         filt_r <= fpcp_pkg::HOST_SYNC_RST;
      end else if (ce_in) begin
         s1_r <= {link.init_done, link.load_complete, link.config_status_n};
         s2_r <= s1_r;
         s3_r <= s2_r;
         filt_r <= filt_nxt;
      end
   end

   // ----------------------------------------
   // Sequencer and clock divider
   // ----------------------------------------
   fpcp_hstate_t st_r;
   fpcp_hstate_t st_nxt;
   logic [17:0] tmr_r;
   logic [17:0] tmr_nxt;
   logic [17:0] lim_r;
   logic [17:0] lim_nxt;
   logic [2:0] ph_r;
   logic [2:0] ph_nxt;
   logic lclk_r;
   logic lclk_nxt;
   logic req_r;
   logic req_nxt;
   logic [31:0] data_r;
   logic [31:0] data_nxt;
   logic have_r;
   logic have_nxt;
   logic [3:0] left_r;
   logic [3:0] left_nxt;
   logic [3:0] ratio_r;
   logic [3:0] ratio_nxt;
   fpcp_pkg::fpcp_width_t width_r;
   fpcp_pkg::fpcp_width_t width_nxt;
   logic [31:0] sent_r;
   logic [31:0] sent_nxt;
   logic [31:0] total_r;
   logic [31:0] total_nxt;
   logic [1:0] fall_r;
   logic [1:0] fall_nxt;
   wire tick;
   wire take;
   wire status_rise;

   assign tick = (ph_r == HALF_LIM);
   assign take = word_ready_out & word_valid_in;
   assign status_rise = filt_nxt[0] & ~filt_r[0];

   always_comb begin
      st_nxt = st_r;
      tmr_nxt = tmr_r + 18'h1;
      lim_nxt = lim_r;
      ph_nxt = tick ? 3'h0 : ph_r + 3'h1;
      lclk_nxt = lclk_r;
      req_nxt = req_r;
      data_nxt = data_r;
      have_nxt = have_r;
      left_nxt = left_r;
      ratio_nxt = ratio_r;
      width_nxt = width_r;
      sent_nxt = sent_r;
      total_nxt = total_r;
      fall_nxt = fall_r;
      unique case (st_r)
         H_IDLE, H_END: begin
            lclk_nxt = 1'b0;
            if (start_in) begin
               st_nxt = H_REQ;
               req_nxt = 1'b0;
               tmr_nxt = 18'h0;
               ratio_nxt = fpcp_pkg::fpcp_ratio(width_in, decomp_in, secure_in);
               width_nxt = width_in;
               total_nxt = words_total_in;
               sent_nxt = 32'h0;
               have_nxt = 1'b0;
            end
         end
         H_REQ: begin
            if (tmr_r == CFG_LIM) begin
               req_nxt = 1'b1;
               tmr_nxt = 18'h0;
               st_nxt = watch_status_in ? H_WST : H_GAP;
               lim_nxt = watch_status_in ? ST2CK_LIM : CF2CK_LIM;
            end
         end
         H_WST: begin
            tmr_nxt = 18'h0;
            if (status_rise) begin
               st_nxt = H_GAP;
            end
         end
         H_GAP: begin
            ph_nxt = 3'h0;
            if (tmr_r == lim_r) begin
               st_nxt = H_LOAD;
            end
         end
         H_LOAD: begin
            if (take) begin
               // Data set up a full half period before the rising edge
               data_nxt = word_in & fpcp_pkg::fpcp_lane_mask(width_r);
               have_nxt = 1'b1;
               left_nxt = ratio_r;
               sent_nxt = sent_r + 32'h1;
               ph_nxt = 3'h0;
            end else if (tick) begin
               if (lclk_r) begin
                  lclk_nxt = 1'b0;
                  if (!have_r && sent_r == total_r) begin
                     st_nxt = H_WDONE;
                  end
               end else if (have_r) begin
                  lclk_nxt = 1'b1;
                  left_nxt = left_r - 4'h1;
                  have_nxt = (left_r != 4'h1);
               end
            end
         end
         H_WDONE: begin
            fall_nxt = 2'h0;
            if (filt_r[1]) begin
               st_nxt = H_EDGES;
            end
         end
         H_EDGES: begin
            if (tick) begin
               lclk_nxt = ~lclk_r;
               if (lclk_r) begin
                  fall_nxt = fall_r + 2'h1;
                  if (fall_r == FALL_LIM) begin
                     st_nxt = H_END;
                  end
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         st_r <= H_IDLE;
         tmr_r <= 18'h0;
         lim_r <= 18'h0;
         ph_r <= 3'h0;
         lclk_r <= 1'b0;
         req_r <= 1'b1;
         data_r <= 32'h0;
         have_r <= 1'b0;
         left_r <= 4'h0;
         ratio_r <= 4'h1;
         width_r <= fpcp_pkg::FPCP_W8;
         sent_r <= 32'h0;
         total_r <= 32'h0;
         fall_r <= 2'h0;
         word_ready_out <= 1'b0;
         busy_out <= 1'b0;
         done_out <= 1'b0;
      end else if (ce_in) begin
         st_r <= st_nxt;
         tmr_r <= tmr_nxt;
         lim_r <= lim_nxt;
         ph_r <= ph_nxt;
         lclk_r <= lclk_nxt;
         req_r <= req_nxt;
         data_r <= data_nxt;
         have_r <= have_nxt;
         left_r <= left_nxt;
         ratio_r <= ratio_nxt;
         width_r <= width_nxt;
         sent_r <= sent_nxt;
         total_r <= total_nxt;
         fall_r <= fall_nxt;
         // New word only while the clock is low, so data never moves just after a rise
         word_ready_out <= (st_nxt == H_LOAD) && !have_nxt && !lclk_nxt
            && (sent_nxt != total_nxt);
         busy_out <= (st_nxt != H_IDLE) && (st_nxt != H_END);
         done_out <= (st_nxt == H_END);
      end
   end

   assign link.load_clock = lclk_r;
   assign link.reconfig_request_n = req_r;
   assign link.data = data_r;
endmodule

// [fpcp_assertions.sv]
// Interface checks for the parallel configuration port
`timescale 1ns/1ns
module fpcp_assertions #(
   parameter int STATUS_CYC = 30,
   parameter int CF2CK_CYC = 60
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic load_clock,
   input wire logic reconfig_request_n,
   input wire logic [31:0] data,
   input wire logic config_status_n,
   input wire logic load_complete,
   input wire logic init_done
);
   // ------
   // Level duration counters
   // ------
   int req_lo_r;
   int req_hi_r;
   int st_lo_r;
   int st_hi_r;
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         req_lo_r <= 0;
         req_hi_r <= 0;
         st_lo_r <= 0;
         st_hi_r <= 0;
      end else begin
         req_lo_r <= reconfig_request_n ? 0 : req_lo_r + 1;
         req_hi_r <= reconfig_request_n ? req_hi_r + 1 : 0;
         st_lo_r <= config_status_n ? 0 : st_lo_r + 1;
         st_hi_r <= config_status_n ? st_hi_r + 1 : 0;
      end
   end
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_b_in);
   // ------
   // Properties
   // ------
   AST_REQ_STATUS: assert property ($fell(reconfig_request_n) |-> ##[0:75] !config_status_n)
      else $error("status not pulled low after request");
   AST_REQ_DONE: assert property ($fell(reconfig_request_n) |-> ##[0:75] !load_complete)
      else $error("load complete not pulled low after request");
   AST_REQ_WIDTH: assert property ($rose(reconfig_request_n) |-> req_lo_r >= 249)
      else $error("request pulse too short");
   AST_STATUS_MIN: assert property ($rose(config_status_n) |-> st_lo_r >= STATUS_CYC)
      else $error("status low pulse too short");
   AST_STATUS_MAX: assert property ($rose(reconfig_request_n) |-> ##[1:60] config_status_n)
      else $error("status not released after request high");
   AST_DONE_LOW: assert property (!config_status_n && reconfig_request_n |-> !load_complete)
      else $error("load complete high during status pulse");
   AST_DONE_HOLD: assert property (load_complete && reconfig_request_n |=> load_complete)
      else $error("load complete dropped without request");
   AST_FIRST_EDGE: assert property ($rose(load_clock) |-> st_hi_r >= 249 || req_hi_r >= CF2CK_CYC - 1)
      else $error("load clock edge too early");
   AST_DATA_HOLD: assert property ($rose(load_clock) |-> $stable(data) ##1 $stable(data))
      else $error("data moved around load clock edge");
   AST_INIT_LOW: assert property (!init_done && reconfig_request_n |-> load_complete)
      else $error("init done low before load complete");
   CV_DONE: cover property ($rose(load_complete));
   CV_STATUS: cover property ($rose(config_status_n));
   CV_INIT: cover property ($fell(init_done));
endmodule

// [fast_parallel_config_port_test.sv]
// Self-checking bench for the parallel configuration port
`timescale 1ns/1ns
module fast_parallel_config_port_test;
   // Rows: width, decompression, security, expected clocks per word
   localparam logic [7:0] ROWS [12] = '{8'h01, 8'h11, 8'h22, 8'h32, 8'h41, 8'h52,
      8'h64, 8'h74, 8'h81, 8'h94, 8'ha8, 8'hb8};
   localparam int POR_F = 40, POR_S = 80, ST_CYC = 30, UM_CYC = 20, UM_CLKS = 5, CK_CYC = 60;
   logic clk_in, rst_b_in, start, decomp, secure, por_fast, idone_en, uclk_sel, uclk;
   logic watch, wvalid, dev_valid, user_mode, ready, done, busy, ce;
   logic [31:0] nwords, word, dev_word, seen, mask;
   fpcp_pkg::fpcp_width_t width;
   int bad_count, n_compared, rises, k;
   // ------
   // Clocks and units
   // ------
   initial begin
      clk_in = 0;
      forever #4 clk_in = ~clk_in;
   end
   initial begin
      uclk = 0;
      #5;
      forever #32 uclk = ~uclk;
   end
   always @(posedge u_fpcp_if.load_clock) rises++;
   always @(posedge clk_in) if (dev_valid === 1'b1) seen <= dev_word;
   fpcp_if u_fpcp_if();
   fpcp_dev #(.POR_FAST_CYC(POR_F), .POR_STD_CYC(POR_S), .STATUS_CYC(ST_CYC),
      .CD2UM_CYC(UM_CYC), .UM_USER_CLKS(UM_CLKS)) u_fpcp_dev (.clk_in(clk_in),
      .rst_b_in(rst_b_in), .ce_in(ce),
      .link(u_fpcp_if.dev), .width_in(width), .decomp_in(decomp), .secure_in(secure),
      .por_fast_in(por_fast), .init_done_en_in(idone_en), .user_clk_sel_in(uclk_sel),
      .user_init_clock_in(uclk), .words_expected_in(nwords), .word_out(dev_word),
      .word_valid_out(dev_valid), .user_mode_out(user_mode));
   fpcp_host #(.CF2CK_CYC(CK_CYC)) u_fpcp_host (.clk_in(clk_in), .rst_b_in(rst_b_in),
      .ce_in(ce), .link(u_fpcp_if.host), .start_in(start), .width_in(width),
      .decomp_in(decomp), .secure_in(secure), .watch_status_in(watch),
      .words_total_in(nwords), .word_in(word), .word_valid_in(wvalid),
      .word_ready_out(ready), .busy_out(busy), .done_out(done));
   fpcp_assertions #(.STATUS_CYC(ST_CYC), .CF2CK_CYC(CK_CYC)) u_fpcp_assertions (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in), .load_clock(u_fpcp_if.load_clock),
      .reconfig_request_n(u_fpcp_if.reconfig_request_n), .data(u_fpcp_if.data),
      .config_status_n(u_fpcp_if.config_status_n), .load_complete(u_fpcp_if.load_complete),
      .init_done(u_fpcp_if.init_done));
   // ------
   // Tasks
   // ------
   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic print_verdict;
      $display("Checks %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic send(input logic [31:0] w);
      step(1);
      word = w;
      wvalid = 1'b1;
      k = 0;
      do @(posedge clk_in); while (ready !== 1'b1 && ++k < 2000);
      check("taken", {31'h0, ready}, 32'h1);
      #1 wvalid = 1'b0;
   endtask
   task automatic run(input logic [7:0] r, input logic [2:0] opt, input logic [31:0] n);
      width = fpcp_pkg::fpcp_width_t'(r[7:6]);
      {decomp, secure} = r[5:4];
      {watch, idone_en, uclk_sel} = opt;
      nwords = n;
      seen = '0;
      start = 1'b1;
      step(1);
      start = 1'b0;
      rises = 0;
      for (int j = 1; j <= n; j++)
         send(32'ha5c3_5af0 + j);
      mask = r[7] ? 32'hffffffff : (r[6] ? 32'h0000ffff : 32'h000000ff);
      k = 0;
      while (u_fpcp_if.load_complete !== 1'b1 && k < 4000) begin
         step(1);
         k++;
      end
      check("init_done", {30'h0, u_fpcp_if.load_complete, u_fpcp_if.init_done},
         {30'h0, 1'b1, !idone_en});
      k = 0;
      while (done !== 1'b1 && k < 4000) begin
         step(1);
         k++;
      end
      check("done", {30'h0, busy, done}, 32'h1);
      check("word", seen, (32'ha5c3_5af0 + n) & mask);
      check("rises", rises, r[3:0] * n + 2);
      k = 0;
      while (user_mode !== 1'b1 && k < 500) begin
         step(1);
         k++;
      end
      check("pins", {28'h0, user_mode, u_fpcp_if.config_status_n, u_fpcp_if.load_complete,
         u_fpcp_if.init_done}, 32'hf);
   endtask
   // ------
   // Sequence
   // ------
   initial begin
      rst_b_in = 0;
      {start, wvalid, decomp, secure, watch, idone_en, uclk_sel} = '0;
      {por_fast, ce} = 2'b11;
      word = 0;
      nwords = 2;
      seen = 0;
      width = fpcp_pkg::FPCP_W8;
      bad_count = 0;
      n_compared = 0;
      rises = 0;
      step(6);
      rst_b_in = 1;
      for (int i = 0; i < 12; i++)
         run(ROWS[i], 3'(i), 32'd2);
      start = 1'b1;
      step(1);
      start = 1'b0;
      send(32'h1234_5678);
      rst_b_in = 0;
      step(2);
      check("reset lines", {30'h0, u_fpcp_if.config_status_n, u_fpcp_if.load_complete}, 0);
      rst_b_in = 1;
      step(20);
      check("por status", {31'h0, u_fpcp_if.config_status_n}, 0);
      ce = 1'b0;
      step(40);
      check("ce freeze", {31'h0, u_fpcp_if.config_status_n}, 0);
      ce = 1'b1;
      run(8'h81, 3'h1, 32'd1);
      print_verdict;
   end
   initial begin
      #300000;
      bad_count++;
      print_verdict;
   end
endmodule
